//--- verilog/pport_consts.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef PPORT_CONSTS_SVH
`define PPORT_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_PRINT_DATA 4'h0
`define IDX_PRINTER_CONDITION 4'h1
`define IDX_PRINTER_CONTROL 4'h2
`define IDX_EPP_ADDRESS 4'h3
`define IDX_EPP_DATA_0 4'h4
`define IDX_EPP_DATA_3 4'h7
`define IDX_PORT_MODE 4'h8

// Control field positions.
`define CTL_STROBE 0
`define CTL_AUTO_LINEFEED 1
`define CTL_INIT_N 2
`define CTL_SELECT 3
`define CTL_IRQ_EN 4
`define CTL_DIR 5

// Status field positions.
`define STS_TIMEOUT 0

// Reset values: strobe, autofeed and select off, init released, output.
`define CTL_RESET 6'h04
`define DATA_RESET 8'h00
`define IDLE_BUS 8'hFF

// Watchdog: 10 us at a 50 ns clock.
`define EPP_TIMEOUT_NS 10000
`define CLK_PERIOD_NS 50
`define EPP_TIMEOUT_CYC (`EPP_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

//--- verilog/pport_pkg.sv
// Types shared by the parallel port register block.
package pport_pkg;
   // Operating modes of the port, chosen by software configuration.
   typedef enum logic [1:0] {
      MODE_SPP,
      MODE_BPP,
      MODE_EPP,
      MODE_ECP
   } port_mode_t;

   // Bus slave and EPP cycle sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RESP,
      ST_EPP_READY,
      ST_EPP_PULSE
   } seq_state_t;
endpackage : pport_pkg

//--- verilog/parallel_port_epp_registers.sv
// Parallel printer port with EPP address/data windows behind Avalon-MM.
//
// Summary of operation
// - Modes SPP, BPP, EPP, ECP share one bus.
// - Four address bits select nine registers.
// - EPP windows run an EPP cycle only in EPP mode; in other modes they read 0xFF.
// - Data read returns the printer data latch.
// - Status byte packs printer pins and timeout.
// - Bit 6 mirrors the live acknowledge pin.
// - EPP cycle over 10 us sets timeout.
// - Writing 1 clears timeout, 0 ignored.
// - Control write stores six control bits.
// - Control readback: ones above, settings below.
// - EPP reuses strobe, autofeed, select pins.
// - Paper end, online, fault shown as status.
// - Watchdog aborts cycle when wait stays high or low.
// - Direction bit sets bus input or output outside SPP mode.
// - Acknowledge rising edge interrupts when enabled.
// - EPP cycle starts on wait low, ends high.
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`include "pport_consts.svh"

module parallel_port_epp_registers (
   // Clock and synchronous reset.
   input wire logic core_clk,
   input wire logic reset_n,
   // Avalon-MM register slave.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Eight-bit two-way printer data bus.
   input wire logic [7:0] parallel_bus_in,
   output logic [7:0] parallel_bus_out,
   output logic parallel_bus_oe,
   // Printer control pins, all active low at the connector.
   output logic strobe_out_n,
   output logic auto_linefeed_out_n,
   output logic select_printer_out_n,
   output logic peripheral_initialize_n,
   // Printer condition pins.
   input wire logic busy_in,
   input wire logic ack_n_in,
   input wire logic media_empty_in,
   input wire logic printer_online_in,
   input wire logic fault_n_in,
   // Acknowledge interrupt, one-cycle pulse.
   output logic ack_irq
);
   import pport_pkg::*;

   // Sequencer state and bus answer.
   seq_state_t state_reg, state_next;
   logic [31:0] rdata_reg, rdata_next;
   logic wait_reg, wait_next;
   // Software-visible registers.
   logic [7:0] data_reg, data_next;
   logic [5:0] ctl_reg, ctl_next;
   logic timeout_reg, timeout_next;
   port_mode_t mode_reg, mode_next;
   // EPP cycle context: direction, address or data, write byte.
   logic epp_write_reg, epp_write_next;
   logic epp_addr_reg, epp_addr_next;
   logic [7:0] epp_wdata_reg, epp_wdata_next;
   logic [7:0] timer_reg, timer_next;
   // Registered pins.
   logic [7:0] bus_out_reg, bus_out_next;
   logic bus_oe_reg, bus_oe_next;
   logic stb_reg, stb_next;
   logic afd_reg, afd_next;
   logic sel_pin_reg, sel_pin_next;
   logic init_reg, init_next;
   logic ack_prev_reg, ack_prev_next;
   logic irq_reg, irq_next;
   // Decoded request.
   logic [3:0] idx;
   logic req;

   // Status byte assembled from live pins and the timeout flag.
   function automatic logic [7:0] status_byte(input logic busy,
                                              input logic ack_n,
                                              input logic empty,
                                              input logic online,
                                              input logic err_n,
                                              input logic tmo);
      // printer condition
      // Bit 7 reads the inverse of busy, so 0 means the printer is busy.
      status_byte = {~busy, ack_n, empty, online, err_n, 2'b11, tmo};
   endfunction : status_byte

   // True for the address window and the four data windows.
   function automatic logic is_epp_window(input logic [3:0] i);
      is_epp_window = (i >= `IDX_EPP_ADDRESS) && (i <= `IDX_EPP_DATA_3);
   endfunction : is_epp_window

   assign idx = avs_address[5:2];
   assign req = avs_read | avs_write;

   // Next-state logic for the slave, the EPP sequencer and the pins.
   always_comb
   begin
      state_next = state_reg;
      rdata_next = rdata_reg;
      wait_next = 1'b1;
      data_next = data_reg;
      ctl_next = ctl_reg;
      timeout_next = timeout_reg;
      mode_next = mode_reg;
      epp_write_next = epp_write_reg;
      epp_addr_next = epp_addr_reg;
      epp_wdata_next = epp_wdata_reg;
      timer_next = timer_reg;
      ack_prev_next = ack_n_in;
      irq_next = ctl_reg[`CTL_IRQ_EN] & ack_n_in & ~ack_prev_reg;
      case (state_reg)
         ST_IDLE:
         begin
            // A request is taken here and normally answered next cycle.
            if (req)
            begin
               state_next = ST_RESP;
               wait_next = 1'b0;
               rdata_next = 32'h0000_0000;
               if (is_epp_window(idx))
               begin
                  if (mode_reg == MODE_EPP)
                  begin
                     // Hold the answer until the EPP cycle completes.
                     state_next = ST_EPP_READY;
                     wait_next = 1'b1;
                     epp_write_next = avs_write;
                     epp_addr_next = (idx == `IDX_EPP_ADDRESS);
                     epp_wdata_next = avs_writedata[7:0];
                     timer_next = 8'h00;
                  end
                  else
                  begin
                     rdata_next = {24'h00_0000, `IDLE_BUS};
                  end
               end
               else if (avs_write)
               begin
                  case (idx)
                     `IDX_PRINT_DATA: data_next = avs_writedata[7:0];
                     `IDX_PRINTER_CONDITION:
                     begin
                        if (avs_writedata[`STS_TIMEOUT])
                        begin
                           timeout_next = 1'b0;
                        end
                     end
                     `IDX_PRINTER_CONTROL:
                     begin
                        ctl_next = avs_writedata[5:0];
                     end
                     `IDX_PORT_MODE:
                     begin
                        mode_next = port_mode_t'(avs_writedata[1:0]);
                     end
                     // Unmapped writes are acknowledged and dropped.
                     default: data_next = data_reg;
                  endcase
               end
               else
               begin
                  case (idx)
                     `IDX_PRINT_DATA:
                     begin
                        rdata_next = {24'h00_0000, data_reg};
                     end
                     `IDX_PRINTER_CONDITION:
                     begin
                        rdata_next = {24'h00_0000,
                           status_byte(busy_in, ack_n_in, media_empty_in,
                              printer_online_in, fault_n_in, timeout_reg)};
                     end
                     `IDX_PRINTER_CONTROL:
                     begin
                        rdata_next = {24'h00_0000, 3'b111, ctl_reg[4:0]};
                     end
                     `IDX_PORT_MODE: rdata_next = {30'h0000_0000, mode_reg};
                     // Unmapped reads return zero.
                     default: rdata_next = 32'h0000_0000;
                  endcase
               end
            end
         end
         // The master samples the answer at this edge and releases.
         ST_RESP: state_next = ST_IDLE;
         ST_EPP_READY:
         begin
            timer_next = timer_reg + 8'h01;
            if (timer_reg >= 8'(`EPP_TIMEOUT_CYC - 1))
            begin
               timeout_next = 1'b1;
               state_next = ST_RESP;
               wait_next = 1'b0;
               rdata_next = {24'h00_0000, parallel_bus_in};
            end
            else if (!busy_in)
            begin
               state_next = ST_EPP_PULSE;
            end
         end
         ST_EPP_PULSE:
         begin
            timer_next = timer_reg + 8'h01;
            if (busy_in)
            begin
               state_next = ST_RESP;
               wait_next = 1'b0;
               rdata_next = {24'h00_0000, parallel_bus_in};
            end
            else if (timer_reg >= 8'(`EPP_TIMEOUT_CYC - 1))
            begin
               timeout_next = 1'b1;
               state_next = ST_RESP;
               wait_next = 1'b0;
               rdata_next = {24'h00_0000, parallel_bus_in};
            end
         end
         default: state_next = ST_IDLE;
      endcase

      // direction control
      // Standard mode forces output; otherwise the direction bit decides.
      bus_oe_next = (mode_reg == MODE_SPP) | ~ctl_reg[`CTL_DIR];
      bus_out_next = data_reg;
      // Outside an EPP cycle the pins follow the control register.
      stb_next = ~ctl_reg[`CTL_STROBE];
      afd_next = ~ctl_reg[`CTL_AUTO_LINEFEED];
      sel_pin_next = ~ctl_reg[`CTL_SELECT];
      init_next = ctl_reg[`CTL_INIT_N];
      if (state_reg == ST_EPP_READY || state_reg == ST_EPP_PULSE)
      begin
         stb_next = ~epp_write_reg;
         bus_oe_next = epp_write_reg;
         bus_out_next = epp_wdata_reg;
         if (state_next == ST_EPP_PULSE)
         begin
            afd_next = epp_addr_reg;
            sel_pin_next = ~epp_addr_reg;
         end
         else
         begin
            afd_next = 1'b1;
            sel_pin_next = 1'b1;
         end
      end
   end

   // Register every state bit; reset is synchronous.
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         state_reg <= ST_IDLE;
         rdata_reg <= 32'h0000_0000;
         wait_reg <= 1'b1;
         data_reg <= `DATA_RESET;
         ctl_reg <= `CTL_RESET;
         timeout_reg <= 1'b0;
         mode_reg <= MODE_SPP;
         epp_write_reg <= 1'b0;
         epp_addr_reg <= 1'b0;
         epp_wdata_reg <= 8'h00;
         timer_reg <= 8'h00;
         bus_out_reg <= `DATA_RESET;
         bus_oe_reg <= 1'b1;
         stb_reg <= 1'b1;
         afd_reg <= 1'b1;
         sel_pin_reg <= 1'b1;
         init_reg <= 1'b1;
         ack_prev_reg <= 1'b1;
         irq_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         wait_reg <= wait_next;
         data_reg <= data_next;
         ctl_reg <= ctl_next;
         timeout_reg <= timeout_next;
         mode_reg <= mode_next;
         epp_write_reg <= epp_write_next;
         epp_addr_reg <= epp_addr_next;
         epp_wdata_reg <= epp_wdata_next;
         timer_reg <= timer_next;
         bus_out_reg <= bus_out_next;
         bus_oe_reg <= bus_oe_next;
         stb_reg <= stb_next;
         afd_reg <= afd_next;
         sel_pin_reg <= sel_pin_next;
         init_reg <= init_next;
         ack_prev_reg <= ack_prev_next;
         irq_reg <= irq_next;
      end
   end

   // Every output comes straight from a flip-flop.
   assign avs_readdata = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign parallel_bus_out = bus_out_reg;
   assign parallel_bus_oe = bus_oe_reg;
   assign strobe_out_n = stb_reg;
   assign auto_linefeed_out_n = afd_reg;
   assign select_printer_out_n = sel_pin_reg;
   assign peripheral_initialize_n = init_reg;
   assign ack_irq = irq_reg;

endmodule : parallel_port_epp_registers

//--- test/pport_checker.sv
// Checker of register bus answers and printer pin timing.
module pport_checker (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset_n,
   // Register bus.
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Printer pins.
   input wire logic parallel_bus_oe,
   input wire logic strobe_out_n,
   input wire logic auto_linefeed_out_n,
   input wire logic select_printer_out_n,
   input wire logic peripheral_initialize_n,
   input wire logic busy_in,
   input wire logic ack_n_in,
   input wire logic ack_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] idx; // Register index.
   logic done, epp, win, dir_bit; // Answer, mode and window flags.
   logic [3:0] pin_bits; // Written pin control bits.
   logic [4:0] ctl_reg, ctl_next; // Shadow of the stored control.
   logic [1:0] mode_reg, mode_next; // Shadow of the port mode.
   logic [7:0] wait_reg, wait_next; // Cycles a request has waited.
   assign idx = avs_address[5:2];
   assign done = !avs_waitrequest;
   assign epp = mode_reg == 2'h2;
   assign win = idx >= 4'h3 && idx <= 4'h7;
   assign dir_bit = avs_writedata[5];
   assign pin_bits = avs_writedata[3:0];
   // Shadows follow accepted writes, so no design state is peeked at.
   always_comb
   begin
      ctl_next = ctl_reg;
      mode_next = mode_reg;
      wait_next = (avs_read || avs_write) && !done ? wait_reg + 8'h01 : 8'h00;
      if (avs_write && done && idx == 4'h2)
         ctl_next = avs_writedata[4:0];
      if (avs_write && done && idx == 4'h8)
         mode_next = avs_writedata[1:0];
   end
   // Shadow registers; reset gives the documented idle control.
   always_ff @(posedge core_clk)
   begin
      ctl_reg <= reset_n ? ctl_next : 5'h04;
      mode_reg <= reset_n ? mode_next : 2'h0;
      wait_reg <= reset_n ? wait_next : 8'h00;
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   fast_a: assert property (
      ($rose(avs_read) || $rose(avs_write)) && !(epp && win) |=> done)
      else $error("register answer late");
   refuse_a: assert property (
      avs_read && done && win && !epp |-> avs_readdata[7:0] == 8'hFF)
      else $error("window read outside enhanced mode");
   status_a: assert property (
      avs_read && done && idx == 4'h1 |-> avs_readdata[2:1] == 2'h3 &&
      avs_readdata[7:6] == {!$past(busy_in), $past(ack_n_in)})
      else $error("status byte wrong");
   ctlrb_a: assert property (
      avs_read && done && idx == 4'h2 |-> avs_readdata[7:0] == {3'h7, ctl_reg})
      else $error("control readback wrong");
   pins_a: assert property (
      avs_write && done && idx == 4'h2 && !epp |-> ##2 {select_printer_out_n,
      peripheral_initialize_n, auto_linefeed_out_n, strobe_out_n}
      == ($past(pin_bits, 2) ^ 4'hB))
      else $error("control pins wrong");
   dir_a: assert property (
      avs_write && done && idx == 4'h2 |-> ##2
      parallel_bus_oe == !($past(dir_bit, 2) && mode_reg != 2'h0))
      else $error("bus direction wrong");
   pulse_a: assert property (
      epp && ($fell(auto_linefeed_out_n) || $fell(select_printer_out_n))
      |-> !$past(busy_in))
      else $error("cycle pulse while peripheral held");
   irq_a: assert property (
      $rose(ack_n_in) && ctl_reg[4] |=> ack_irq)
      else $error("acknowledge interrupt missing");
   bound_a: assert property (
      wait_reg < 8'hD0)
      else $error("enhanced cycle not aborted");
endmodule : pport_checker

//--- test/pport_printer_model.sv
// Printer and enhanced-mode peripheral seen across the cable.
module pport_printer_model #(
   parameter int DELAY = 3,
   parameter logic [7:0] RD_BYTE = 8'hC3
) (
   // Clock and bench controls.
   input wire logic core_clk,
   input wire logic epp,
   input wire logic stall,
   input wire logic ack_go,
   // Pins from the port.
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   input wire logic strobe_n,
   input wire logic afd_n,
   input wire logic select_n,
   // Pins toward the port and the last byte taken.
   output logic [7:0] bus_in,
   output logic busy,
   output logic ack_n,
   output logic [7:0] got
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] last = 8'h00; // Last bus level, inverted when undriven.
   int cnt = 0; // Cycle counter of the current handshake.
   logic pulse; // A data or address pulse is active.
   assign pulse = epp && !(afd_n && select_n);
   // An undriven bus churns, so stale data never reads as valid.
   assign bus_in = bus_oe ? bus_out : pulse && strobe_n ? RD_BYTE : ~last;
   initial busy = 1'b0;
   initial ack_n = 1'b1;
   initial got = 8'h00;
   // Handshakes; a stalled peripheral never ends the cycle.
   always @(posedge core_clk)
   begin
      last <= bus_in;
      if (epp)
      begin
         cnt <= pulse ? cnt + 1 : 0;
         // wait ends the cycle, cleared after the pulse.
         busy <= pulse && (busy || (cnt == DELAY && !stall));
         if (pulse && cnt == DELAY)
            got <= bus_out;
      end
      else if (cnt != 0 || ack_go)
      begin
         // busy while taking data, acknowledge before release.
         cnt <= cnt == 110 ? 0 : cnt + 1;
         busy <= cnt < 110;
         ack_n <= !(cnt >= 5 && cnt < 105);
      end
   end
endmodule : pport_printer_model

//--- test/parallel_port_epp_registers_test.sv
// Register and pin tests of the parallel port block.
module parallel_port_epp_registers_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0, reset_n = 1'b0; // Clock and reset.
   logic [5:0] avs_address = 6'h00; // Bus request.
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, oe, stb_n, afd_n, sel_n, init_n, irq;
   logic [7:0] b_in, b_out, got, q; // Bus levels and read value.
   logic busy, ack_n, epp = 1'b0, stall = 1'b0, ack_go = 1'b0;
   logic empty = 1'b1, online = 1'b0, fault_n = 1'b0; // Printer state.
   int errors = 0, n_checks = 0, irqs = 0;
   logic [7:0] cv [3] = '{8'hF5, 8'h2A, 8'h04}; // Control values.
   parallel_port_epp_registers i_dut (.core_clk(core_clk),
      .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .parallel_bus_in(b_in), .parallel_bus_out(b_out),
      .parallel_bus_oe(oe), .strobe_out_n(stb_n),
      .auto_linefeed_out_n(afd_n), .select_printer_out_n(sel_n),
      .peripheral_initialize_n(init_n), .busy_in(busy), .ack_n_in(ack_n),
      .media_empty_in(empty), .printer_online_in(online),
      .fault_n_in(fault_n), .ack_irq(irq));
   pport_printer_model i_prn (.core_clk(core_clk), .epp(epp),
      .stall(stall), .ack_go(ack_go), .bus_out(b_out), .bus_oe(oe),
      .strobe_n(stb_n), .afd_n(afd_n), .select_n(sel_n), .bus_in(b_in),
      .busy(busy), .ack_n(ack_n), .got(got));
   always #25 core_clk = ~core_clk;
   // Interrupt pulses are counted as they come.
   always @(posedge core_clk)
      if (irq === 1'b1)
         irqs++;
   // Compare one value and report a difference.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: %h not %h", $time, seen, exp);
      end
   endtask : chk
   // One bus access held until waitrequest is sampled low.
   task automatic acc(input logic wr, input logic [3:0] idx,
      input logic [7:0] d);
      @(posedge core_clk);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h0, d};
      avs_read <= !wr;
      avs_write <= wr;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : acc
   // Verdict printed in one place.
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim
   // A hang is cut short well after the tests should end.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      end_sim();
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      reset_n <= 1'b1;
      acc(0, 4'h2, 8'h00);
      chk(q, 8'hE4);
      chk({stb_n, afd_n, sel_n, init_n, oe}, 8'h1F);
      acc(0, 4'h1, 8'h00);
      chk(q, 8'hE6);
      $display("reset test done");
      // each control value reaches readback and pins.
      foreach (cv[i])
      begin
         acc(1, 4'h2, cv[i]);
         acc(0, 4'h2, 8'h00);
         chk(q, {3'h7, cv[i][4:0]});
         chk({sel_n, init_n, afd_n, stb_n}, {4'h0, cv[i][3:0] ^ 4'hB});
         chk(oe, 8'h01);
      end
      acc(1, 4'h8, 8'h01);
      acc(1, 4'h2, 8'h24);
      repeat (3) @(posedge core_clk);
      chk(oe, 8'h00);
      acc(1, 4'h2, 8'h04);
      acc(1, 4'h0, 8'hA5);
      acc(0, 4'h0, 8'h00);
      chk(q, 8'hA5);
      acc(1, 4'h8, 8'h00);
      acc(1, 4'h4, 8'h99);
      acc(0, 4'h3, 8'h00);
      chk(q, 8'hFF);
      chk(b_out, 8'hA5);
      acc(0, 4'h9, 8'h00);
      chk(q, 8'h00);
      $display("register test done");
      acc(1, 4'h8, 8'h02);
      epp <= 1'b1;
      // every window carries a byte to the peripheral.
      for (int i = 3; i < 8; i++)
      begin
         acc(1, i[3:0], {4'h3, i[3:0]});
         chk(got, {4'h3, i[3:0]});
      end
      acc(0, 4'h5, 8'h00);
      chk(q, 8'hC3);
      stall <= 1'b1;
      acc(1, 4'h4, 8'h11);
      stall <= 1'b0;
      acc(0, 4'h1, 8'h00);
      chk(q, 8'hE7);
      acc(1, 4'h1, 8'h00);
      acc(0, 4'h1, 8'h00);
      chk(q, 8'hE7);
      acc(1, 4'h1, 8'h01);
      acc(0, 4'h1, 8'h00);
      chk(q, 8'hE6);
      $display("enhanced test done");
      acc(1, 4'h8, 8'h00);
      epp <= 1'b0;
      // one interrupt with enable set, none without.
      for (int k = 0; k < 2; k++)
      begin
         acc(1, 4'h2, k == 0 ? 8'h14 : 8'h04);
         ack_go <= 1'b1;
         @(posedge core_clk);
         ack_go <= 1'b0;
         repeat (20) @(posedge core_clk);
         acc(0, 4'h1, 8'h00);
         chk(q, 8'h26);
         repeat (120) @(posedge core_clk);
         chk(irqs[7:0], 8'h01);
      end
      $display("acknowledge test done");
      end_sim();
   end
endmodule : parallel_port_epp_registers_test
bind parallel_port_epp_registers pport_checker i_chk (.core_clk(core_clk),
   .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .parallel_bus_oe(parallel_bus_oe), .strobe_out_n(strobe_out_n),
   .auto_linefeed_out_n(auto_linefeed_out_n),
   .select_printer_out_n(select_printer_out_n),
   .peripheral_initialize_n(peripheral_initialize_n), .busy_in(busy_in),
   .ack_n_in(ack_n_in), .ack_irq(ack_irq));
